// *** src/anp_defs.svh ***
// Behaviour
// - expansion bit 5 latches high while the base page variable is true and alternate next page enable is set.
// - base page flag only meaningful with alternate next page enable set.
// - parallel detection fault latches high until read; resets to zero.
// - read-only flag shows partner advertised next page ability.
// - read-only flag shows local next page ability, one after reset.
// - page arrival sets page received, loads base or next page register.
// - reading the expansion register clears page received after returning it.
// - with alternate feature, page received clears on arrived false or inhibit.
// - read-only flag shows partner auto-negotiation ability, zero after reset.
// - transmit reserved bit 14 reads zero; writes to it are ignored.
// - toggle bits hold the inverse of the previous transmitted toggle; here the transmit toggle is whatever software writes.
// - partner next page register shows partner more pages flag, reset zero.
// - partner next page register shows partner acknowledge bit.
// - partner next page register shows message or unformatted page.
// - partner next page register shows partner comply flag.
`ifndef ANP_DEFS_SVH
`define ANP_DEFS_SVH

`define ANP_REG_BASE_PAGE   5'h05
`define ANP_REG_EXPANSION   5'h06
`define ANP_REG_NP_TX       5'h07
`define ANP_REG_NP_RX       5'h08

`define ANP_WORD_ZERO       16'h0000
`define ANP_NP_TX_RESET     16'h2001
`define ANP_NP_RX_RESET     16'h0000
`define ANP_BASE_RESET      16'h0000
`define ANP_NP_TX_RSV_MASK  16'h4000

`define ANP_BIT_BASE_PAGE   5
`define ANP_BIT_PD_FAULT    4
`define ANP_BIT_LP_NP_ABLE  3
`define ANP_BIT_NP_ABLE     2
`define ANP_BIT_PAGE_RX     1
`define ANP_BIT_LP_AN_ABLE  0
`define ANP_BIT_TX_RSV      14
`define ANP_LOCAL_NP_ABLE   1'b1

`define ANP_FLAG_BASE       0
`define ANP_FLAG_PD         1
`define ANP_FLAG_PR         2
`define ANP_NUM_LH          3

`define ANP_HDR_ST          12
`define ANP_HDR_OP_HI       11
`define ANP_HDR_OP_LO       10
`define ANP_HDR_PHY_HI      9
`define ANP_HDR_PHY_LO      5
`define ANP_HDR_REG_HI      4
`define ANP_HDR_REG_LO      0
`define ANP_OP_READ         2'h2
`define ANP_OP_WRITE        2'h1

`define ANP_PRE_ONES        6'h20
`define ANP_CNT_ZERO        4'h0
`define ANP_CNT_ONE         4'h1
`define ANP_HDR_LAST        4'hc
`define ANP_DATA_LAST       4'hf

`endif

// *** src/anp_pkg.sv ***
`default_nettype none
package anp_pkg;

   typedef logic [15:0] anp_word_t;

   typedef enum logic [3:0] {
      ST_PRE  = 4'h1,
      ST_HDR  = 4'h2,
      ST_TA   = 4'h4,
      ST_DATA = 4'h8
   } anp_mdio_state_t;

endpackage : anp_pkg
`default_nettype wire

// *** src/anp_lh_flag.sv ***
`timescale 1ns/1ns
`default_nettype none
module anp_lh_flag (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic set,
   input  wire logic clr,
   output var  logic flag_q
);
   import anp_pkg::*;

   logic flag_d;

   // set beats clear so an event landing on the read is kept
   always_comb
   begin
      flag_d = flag_q;
      if (clr)
         flag_d = 1'b0;
      if (set)
         flag_d = 1'b1;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         flag_q <= 1'b0;
      else
         flag_q <= flag_d;
   end

   set_wins_a: assert property (@(posedge clock) disable iff (!rst_n) set |=> flag_q)
      else $error("latched flag lost a set");

endmodule : anp_lh_flag
`default_nettype wire

// *** src/anp_np_regs.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "anp_defs.svh"
module anp_np_regs (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic             mdc,
   input  wire logic             mdio_i,
   output var  logic             mdio_o,
   output var  logic             mdio_oe,
   input  wire logic [4:0]       phy_addr,
   input  wire logic             alt_np_enable,
   input  wire logic             page_rx_pulse,
   input  wire logic             page_is_base,
   input  wire anp_pkg::anp_word_t page_word,
   input  wire logic             page_arrived_var,
   input  wire logic             send_inhibit_var,
   input  wire logic             base_page_var,
   input  wire logic             pd_fault_pulse,
   input  wire logic             lp_np_able,
   input  wire logic             lp_an_able,
   output var  anp_pkg::anp_word_t np_tx_word,
   output var  logic             np_tx_written
);
   import anp_pkg::*;

   // pin synchronisers
   logic            mdc_m_q, mdc_s_q, mdc_h_q;
   logic            mdio_m_q, mdio_s_q;
   logic [4:0]      phy_m_q, phy_s_q;

   // management frame state
   anp_mdio_state_t st_q, st_d;
   logic [5:0]      ones_q, ones_d;
   logic [3:0]      cnt_q, cnt_d;
   logic [11:0]     hdr_q, hdr_d;
   logic [4:0]      reg_q, reg_d;
   logic            rd_q, rd_d;
   logic            wr_q, wr_d;
   anp_word_t       sh_q, sh_d;
   logic            mdio_o_d, mdio_oe_d;
   logic            rise;
   logic [12:0]     hdr_full;
   logic            hdr_done;
   logic            rd6_clr;
   logic            wr_commit;
   anp_word_t       wr_word;

   // page registers
   anp_word_t       base_q, base_d;
   anp_word_t       np_rx_q, np_rx_d;
   anp_word_t       np_tx_q, np_tx_d;
   logic            lp_np_q, lp_an_q;
   logic            np_wr_d;
   logic [`ANP_NUM_LH-1:0] lh_set, lh_clr, lh_q;
   anp_word_t       exp_word;

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         mdc_m_q  <= 1'b0;
         mdc_s_q  <= 1'b0;
         mdc_h_q  <= 1'b0;
         mdio_m_q <= 1'b1;
         mdio_s_q <= 1'b1;
         phy_m_q  <= 5'h00;
         phy_s_q  <= 5'h00;
      end
      else
      begin
         mdc_m_q  <= mdc;
         mdc_s_q  <= mdc_m_q;
         mdc_h_q  <= mdc_s_q;
         mdio_m_q <= mdio_i;
         mdio_s_q <= mdio_m_q;
         phy_m_q  <= phy_addr;
         phy_s_q  <= phy_m_q;
      end
   end

   assign rise     = mdc_s_q & ~mdc_h_q;
   assign hdr_full = {hdr_q, mdio_s_q};

   always_comb
   begin
      exp_word                      = `ANP_WORD_ZERO;
      exp_word[`ANP_BIT_BASE_PAGE]  = lh_q[`ANP_FLAG_BASE];
      exp_word[`ANP_BIT_PD_FAULT]   = lh_q[`ANP_FLAG_PD];
      exp_word[`ANP_BIT_LP_NP_ABLE] = lp_np_q;
      exp_word[`ANP_BIT_NP_ABLE]    = `ANP_LOCAL_NP_ABLE;
      exp_word[`ANP_BIT_PAGE_RX]    = lh_q[`ANP_FLAG_PR];
      exp_word[`ANP_BIT_LP_AN_ABLE] = lp_an_q;
   end

   function automatic anp_word_t read_mux(input logic [4:0] a, input anp_word_t e,
                                          input anp_word_t b, input anp_word_t t,
                                          input anp_word_t r);
      case (a)
         `ANP_REG_BASE_PAGE: read_mux = b;
         `ANP_REG_EXPANSION: read_mux = e;
         `ANP_REG_NP_TX:     read_mux = t;
         `ANP_REG_NP_RX:     read_mux = r;
         default:            read_mux = `ANP_WORD_ZERO;
      endcase
   endfunction : read_mux

   // header is complete on the rise that samples its thirteenth bit
   assign hdr_done  = rise && (st_q == ST_HDR) && (cnt_q == `ANP_HDR_LAST);
   assign rd6_clr   = hdr_done && hdr_full[`ANP_HDR_ST]
                      && (hdr_full[`ANP_HDR_OP_HI:`ANP_HDR_OP_LO] == `ANP_OP_READ)
                      && (hdr_full[`ANP_HDR_PHY_HI:`ANP_HDR_PHY_LO] == phy_s_q)
                      && (hdr_full[`ANP_HDR_REG_HI:`ANP_HDR_REG_LO] == `ANP_REG_EXPANSION);
   assign wr_commit = rise && (st_q == ST_DATA) && wr_q && (cnt_q == `ANP_DATA_LAST);
   assign wr_word   = {sh_q[14:0], mdio_s_q};

   always_comb
   begin
      st_d      = st_q;
      ones_d    = ones_q;
      cnt_d     = cnt_q;
      hdr_d     = hdr_q;
      reg_d     = reg_q;
      rd_d      = rd_q;
      wr_d      = wr_q;
      sh_d      = sh_q;
      mdio_o_d  = mdio_o;
      mdio_oe_d = mdio_oe;
      if (rise)
      begin
         case (st_q)
            ST_PRE:
            begin
               if (mdio_s_q)
               begin
                  if (ones_q != `ANP_PRE_ONES)
                     ones_d = ones_q + 6'h01;
               end
               else if (ones_q == `ANP_PRE_ONES)
               begin
                  st_d  = ST_HDR;
                  cnt_d = `ANP_CNT_ZERO;
               end
               else
                  ones_d = 6'h00;
            end
            ST_HDR:
            begin
               hdr_d = hdr_full[11:0];
               cnt_d = cnt_q + 4'h1;
               if (cnt_q == `ANP_HDR_LAST)
               begin
                  rd_d  = 1'b0;
                  wr_d  = 1'b0;
                  reg_d = hdr_full[`ANP_HDR_REG_HI:`ANP_HDR_REG_LO];
                  // a foreign address still walks the frame, bus left alone
                  if (hdr_full[`ANP_HDR_ST] && (hdr_full[`ANP_HDR_PHY_HI:`ANP_HDR_PHY_LO] == phy_s_q))
                  begin
                     rd_d = (hdr_full[`ANP_HDR_OP_HI:`ANP_HDR_OP_LO] == `ANP_OP_READ);
                     wr_d = (hdr_full[`ANP_HDR_OP_HI:`ANP_HDR_OP_LO] == `ANP_OP_WRITE);
                  end
                  // snapshot taken in the same cycle as the clear-on-read
                  sh_d  = read_mux(hdr_full[`ANP_HDR_REG_HI:`ANP_HDR_REG_LO], exp_word,
                                   base_q, np_tx_q, np_rx_q);
                  st_d  = ST_TA;
                  cnt_d = `ANP_CNT_ZERO;
               end
            end
            ST_TA:
            begin
               cnt_d = cnt_q + 4'h1;
               if (cnt_q == `ANP_CNT_ZERO)
               begin
                  mdio_oe_d = rd_q;
                  mdio_o_d  = 1'b0;
               end
               else
               begin
                  st_d     = ST_DATA;
                  cnt_d    = `ANP_CNT_ZERO;
                  mdio_o_d = sh_q[15];
                  if (rd_q)
                     sh_d = {sh_q[14:0], 1'b0};
               end
            end
            ST_DATA:
            begin
               cnt_d = cnt_q + 4'h1;
               if (rd_q)
               begin
                  mdio_o_d = sh_q[15];
                  sh_d     = {sh_q[14:0], 1'b0};
               end
               else
                  sh_d = wr_word;
               if (cnt_q == `ANP_DATA_LAST)
               begin
                  mdio_oe_d = 1'b0;
                  mdio_o_d  = 1'b0;
                  st_d      = ST_PRE;
                  ones_d    = 6'h00;
                  rd_d      = 1'b0;
                  wr_d      = 1'b0;
               end
            end
            default:
            begin
               st_d      = ST_PRE;
               ones_d    = 6'h00;
               mdio_oe_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         st_q    <= ST_PRE;
         ones_q  <= 6'h00;
         cnt_q   <= `ANP_CNT_ZERO;
         hdr_q   <= 12'h000;
         reg_q   <= 5'h00;
         rd_q    <= 1'b0;
         wr_q    <= 1'b0;
         sh_q    <= `ANP_WORD_ZERO;
         mdio_o  <= 1'b0;
         mdio_oe <= 1'b0;
      end
      else
      begin
         st_q    <= st_d;
         ones_q  <= ones_d;
         cnt_q   <= cnt_d;
         hdr_q   <= hdr_d;
         reg_q   <= reg_d;
         rd_q    <= rd_d;
         wr_q    <= wr_d;
         sh_q    <= sh_d;
         mdio_o  <= mdio_o_d;
         mdio_oe <= mdio_oe_d;
      end
   end

   // base page flag is only set while the alternate feature is on
   assign lh_set[`ANP_FLAG_BASE] = base_page_var & alt_np_enable;
   assign lh_clr[`ANP_FLAG_BASE] = rd6_clr;
   assign lh_set[`ANP_FLAG_PD]   = pd_fault_pulse;
   assign lh_clr[`ANP_FLAG_PD]   = rd6_clr;
   assign lh_set[`ANP_FLAG_PR]   = page_rx_pulse;
   assign lh_clr[`ANP_FLAG_PR]   = rd6_clr
                                   | (alt_np_enable & (~page_arrived_var | send_inhibit_var));

   genvar gi;
   generate
      for (gi = 0; gi < `ANP_NUM_LH; gi++)
      begin : g_lh
         anp_lh_flag u_flag (
            .clock  (clock),
            .rst_n  (rst_n),
            .set    (lh_set[gi]),
            .clr    (lh_clr[gi]),
            .flag_q (lh_q[gi])
         );
      end
   endgenerate

   always_comb
   begin
      base_d  = base_q;
      np_rx_d = np_rx_q;
      np_tx_d = np_tx_q;
      np_wr_d = 1'b0;
      if (page_rx_pulse)
      begin
         if (page_is_base)
            base_d = page_word;
         else
            np_rx_d = page_word;
      end
      if (wr_commit && (reg_q == `ANP_REG_NP_TX))
      begin
         // software owns more pages, comply and toggle; bit 14 stays zero
         np_tx_d = wr_word & ~`ANP_NP_TX_RSV_MASK;
         np_wr_d = 1'b1;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         base_q        <= `ANP_BASE_RESET;
         np_rx_q       <= `ANP_NP_RX_RESET;
         np_tx_q       <= `ANP_NP_TX_RESET;
         np_tx_word    <= `ANP_NP_TX_RESET;
         np_tx_written <= 1'b0;
         lp_np_q       <= 1'b0;
         lp_an_q       <= 1'b0;
      end
      else
      begin
         base_q        <= base_d;
         np_rx_q       <= np_rx_d;
         np_tx_q       <= np_tx_d;
         np_tx_word    <= np_tx_d;
         np_tx_written <= np_wr_d;
         lp_np_q       <= lp_np_able;
         lp_an_q       <= lp_an_able;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   pr_set_a: assert property (page_rx_pulse |=> lh_q[`ANP_FLAG_PR])
      else $error("page received flag not set");
   np_load_a: assert property (page_rx_pulse && !page_is_base |=> np_rx_q == $past(page_word))
      else $error("partner next page not loaded");
   base_load_a: assert property (page_rx_pulse && page_is_base |=> base_q == $past(page_word))
      else $error("partner base page not loaded");
   rd_clear_a: assert property (rd6_clr && !page_rx_pulse |=> !lh_q[`ANP_FLAG_PR])
      else $error("page received survived a read");
   alt_clear_a: assert property (alt_np_enable && send_inhibit_var && !page_rx_pulse
                                 |=> !lh_q[`ANP_FLAG_PR])
      else $error("page received not cleared by inhibit");
   pd_hold_a: assert property (lh_q[`ANP_FLAG_PD] && !rd6_clr |=> lh_q[`ANP_FLAG_PD])
      else $error("fault flag dropped without read");
   read_snap_a: assert property (rd6_clr |=> sh_q[`ANP_BIT_NP_ABLE]
                                 && sh_q[`ANP_BIT_PAGE_RX] == $past(lh_q[`ANP_FLAG_PR])
                                 && sh_q[`ANP_BIT_LP_AN_ABLE] == $past(lp_an_q))
      else $error("expansion snapshot wrong");
   tx_rsv_a: assert property (!np_tx_word[`ANP_BIT_TX_RSV])
      else $error("reserved transmit bit set");
   tx_stable_a: assert property (!(wr_commit && reg_q == `ANP_REG_NP_TX) |=> $stable(np_tx_word))
      else $error("transmit word changed without write");
   ta_drive_a: assert property (rise && st_q == ST_TA && cnt_q == `ANP_CNT_ZERO && rd_q
                                |=> mdio_oe && !mdio_o)
      else $error("turnaround zero not driven");

   rx_page_c: cover property (page_rx_pulse && !page_is_base);
   exp_read_c: cover property (rd6_clr && lh_q[`ANP_FLAG_PR]);
   tx_write_c: cover property (np_tx_written);
   set_clear_c: cover property (rd6_clr && page_rx_pulse);

endmodule : anp_np_regs
`default_nettype wire

// *** src/anp_unused_placeholder_removed.sv ***
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// *** bench/anp_mgmt_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module anp_mgmt_model (
   input  wire logic clock,
   input  wire logic mdio_wire,
   output var  logic mdc,
   output var  logic drv_en,
   output var  logic drv_val
);
   // six clocks a half period keeps mdc well above the three-clock minimum
   localparam int HALF = 6;

   initial
   begin
      mdc     = 1'b0;
      drv_en  = 1'b0;
      drv_val = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : wait_clk

   // the wire is taken just before the rise, after the device had three quarters of a period to settle
   task automatic bit_cycle(input logic en, input logic val, output logic seen);
      drv_en  = en;
      drv_val = val;
      wait_clk(HALF);
      seen = mdio_wire;
      mdc  = 1'b1;
      wait_clk(HALF);
      mdc = 1'b0;
   endtask : bit_cycle

   task automatic send_header(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rnum);
      logic [13:0] hdr;
      logic        dummy;
      hdr = {2'b01, op, phy, rnum};
      // no preamble suppression: every frame gets all 32 ones
      for (int i = 0; i < 32; i++)
         bit_cycle(1'b1, 1'b1, dummy);
      for (int i = 13; i >= 0; i--)
         bit_cycle(1'b1, hdr[i], dummy);
   endtask : send_header

   task automatic read_reg(input logic [4:0] phy, input logic [4:0] rnum, output logic [15:0] data);
      logic dummy;
      send_header(2'b10, phy, rnum);
      bit_cycle(1'b0, 1'b0, dummy);
      bit_cycle(1'b0, 1'b0, dummy);
      for (int i = 15; i >= 0; i--)
         bit_cycle(1'b0, 1'b0, data[i]);
      // mdc stands still between frames while the device lets go of the line
      wait_clk(2 * HALF);
   endtask : read_reg

   // software fills more pages and comply bits as it sees fit
   task automatic write_reg(input logic [4:0] phy, input logic [4:0] rnum, input logic [15:0] data);
      logic dummy;
      send_header(2'b01, phy, rnum);
      bit_cycle(1'b1, 1'b1, dummy);
      bit_cycle(1'b1, 1'b0, dummy);
      for (int i = 15; i >= 0; i--)
         bit_cycle(1'b1, data[i], dummy);
      drv_en = 1'b0;
      wait_clk(2 * HALF);
   endtask : write_reg
endmodule : anp_mgmt_model
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
   localparam logic [4:0] PHY   = 5'h0b;
   localparam int         LIMIT = 60000;

   logic               clock;
   logic               rst_n;
   logic               mdc;
   logic               mdio_o;
   logic               mdio_oe;
   logic               m_en;
   logic               m_val;
   wire logic          mdio_wire;
   logic [4:0]         phy_addr;
   logic               alt_np_enable;
   logic               page_rx_pulse;
   logic               page_is_base;
   anp_pkg::anp_word_t page_word;
   logic               page_arrived_var;
   logic               send_inhibit_var;
   logic               base_page_var;
   logic               pd_fault_pulse;
   logic               lp_np_able;
   logic               lp_an_able;
   anp_pkg::anp_word_t np_tx_word;
   logic               np_tx_written;
   logic [15:0]        wr_pulses;
   logic [15:0]        oe_cycles;
   logic [15:0]        oe_before;
   logic [15:0]        rd_val;
   int                 cycles;
   int                 miscompares;
   int                 checks_done;

   // released line floats up through the pull-up
   assign mdio_wire = mdio_oe ? mdio_o : (m_en ? m_val : 1'b1);

   anp_np_regs u_dut (
      .clock            (clock),
      .rst_n            (rst_n),
      .mdc              (mdc),
      .mdio_i           (mdio_wire),
      .mdio_o           (mdio_o),
      .mdio_oe          (mdio_oe),
      .phy_addr         (phy_addr),
      .alt_np_enable    (alt_np_enable),
      .page_rx_pulse    (page_rx_pulse),
      .page_is_base     (page_is_base),
      .page_word        (page_word),
      .page_arrived_var (page_arrived_var),
      .send_inhibit_var (send_inhibit_var),
      .base_page_var    (base_page_var),
      .pd_fault_pulse   (pd_fault_pulse),
      .lp_np_able       (lp_np_able),
      .lp_an_able       (lp_an_able),
      .np_tx_word       (np_tx_word),
      .np_tx_written    (np_tx_written)
   );

   anp_mgmt_model u_mgmt (
      .clock     (clock),
      .mdio_wire (mdio_wire),
      .mdc       (mdc),
      .drv_en    (m_en),
      .drv_val   (m_val)
   );

   initial
   begin
      clock = 1'b0;
   end

   always #10 clock = ~clock;

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run

   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (np_tx_written === 1'b1)
         wr_pulses <= wr_pulses + 16'h0001;
      if (mdio_oe === 1'b1)
         oe_cycles <= oe_cycles + 16'h0001;
      if (cycles == LIMIT)
      begin
         miscompares = miscompares + 1;
         complete_run();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
         miscompares = miscompares + 1;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic rd(input logic [4:0] rnum, input logic [15:0] exp, input string what);
      u_mgmt.read_reg(PHY, rnum, rd_val);
      check(what, rd_val, exp);
   endtask : rd

   task automatic page(input logic base, input logic [15:0] w);
      page_is_base  = base;
      page_word     = w;
      page_rx_pulse = 1'b1;
      tick(1);
      page_rx_pulse = 1'b0;
      tick(2);
   endtask : page

   initial
   begin
      rst_n = 1'b0;
      phy_addr = PHY;
      alt_np_enable = 1'b0;
      page_rx_pulse = 1'b0;
      page_is_base = 1'b0;
      page_word = 16'h0000;
      page_arrived_var = 1'b0;
      send_inhibit_var = 1'b0;
      base_page_var = 1'b0;
      pd_fault_pulse = 1'b0;
      lp_np_able = 1'b0;
      lp_an_able = 1'b0;
      wr_pulses = 16'h0000;
      oe_cycles = 16'h0000;
      cycles = 0;
      miscompares = 0;
      checks_done = 0;
      tick(5);
      rst_n = 1'b1;
      tick(4);
      check("np_tx_word at reset", np_tx_word, 16'h2001);
      rd(5'h06, 16'h0004, "expansion at reset");
      rd(5'h07, 16'h2001, "transmit page at reset");
      rd(5'h08, 16'h0000, "partner page at reset");
      $display("test reset_values done");

      u_mgmt.write_reg(PHY, 5'h07, 16'hffff);
      check("np_tx_word after write", np_tx_word, 16'hbfff);
      check("write pulses", wr_pulses, 16'h0001);
      rd(5'h07, 16'hbfff, "transmit page reserved bit");
      u_mgmt.write_reg(PHY, 5'h07, 16'h0800);
      rd(5'h07, 16'h0800, "transmit page toggle");
      u_mgmt.write_reg(PHY, 5'h08, 16'hffff);
      rd(5'h08, 16'h0000, "partner page write ignored");
      oe_before = oe_cycles;
      u_mgmt.write_reg(5'h0c, 5'h07, 16'h1234);
      u_mgmt.read_reg(5'h0c, 5'h07, rd_val);
      check("foreign address drive", oe_cycles, oe_before);
      check("foreign address write", np_tx_word, 16'h0800);
      rd(5'h1f, 16'h0000, "unmapped register");
      $display("test transmit_register done");

      lp_np_able = 1'b1;
      lp_an_able = 1'b1;
      page(1'b0, 16'hf5a5);
      rd(5'h08, 16'hf5a5, "partner next page");
      rd(5'h06, 16'h000f, "page received set");
      rd(5'h06, 16'h000d, "page received cleared");
      page(1'b1, 16'h1234);
      rd(5'h05, 16'h1234, "partner base page");
      rd(5'h08, 16'hf5a5, "next page kept");
      rd(5'h06, 16'h000f, "base page received");
      page(1'b0, 16'h0a5a);
      rd(5'h08, 16'h0a5a, "partner page zeros");
      $display("test page_receive done");

      pd_fault_pulse = 1'b1;
      tick(1);
      pd_fault_pulse = 1'b0;
      rd(5'h06, 16'h001f, "fault latched");
      rd(5'h06, 16'h000d, "fault cleared");
      $display("test parallel_fault done");

      base_page_var = 1'b1;
      tick(2);
      base_page_var = 1'b0;
      rd(5'h06, 16'h000d, "base page without feature");
      alt_np_enable = 1'b1;
      page_arrived_var = 1'b1;
      base_page_var = 1'b1;
      tick(2);
      base_page_var = 1'b0;
      rd(5'h06, 16'h002d, "base page latched");
      rd(5'h06, 16'h000d, "base page cleared");
      page(1'b0, 16'h1111);
      rd(5'h06, 16'h000f, "page held while arrived");
      page(1'b0, 16'h2222);
      send_inhibit_var = 1'b1;
      tick(2);
      send_inhibit_var = 1'b0;
      rd(5'h06, 16'h000d, "cleared by inhibit");
      page(1'b0, 16'h3333);
      page_arrived_var = 1'b0;
      tick(2);
      page_arrived_var = 1'b1;
      rd(5'h06, 16'h000d, "cleared by arrival drop");
      $display("test alternate_feature done");
      complete_run();
   end
endmodule : tb
`default_nettype wire
